/* rtl/cb_if.sv */
// Purpose: link between the bus unit and the control block memory
// Assumes: one access per request, read data registered
// Notes: word addressed
`timescale 1ns/100ps
`default_nettype none
interface cb_if;
  logic req; // access strobe
  logic we; // write when high
  logic [8:0] addr; // word index
  logic [15:0] wdata; // write data
  logic [1:0] be; // byte enables
  logic [15:0] rdata; // registered read data
  modport master (output req, output we, output addr, output wdata,
    output be, input rdata);
  modport slave (input req, input we, input addr, input wdata,
    input be, output rdata);
endinterface
`default_nettype wire

/* rtl/cb_mem.sv */
// Purpose: 1 Kbyte block of 16-bit peripheral control registers
// Assumes: single port, one cycle read latency
// Notes: holds the peripheral register image on this side
`timescale 1ns/100ps
`default_nettype none
module cb_mem
  import ebiu_pkg::*;
(
  input wire logic ref_clk, // system clock
  cb_if.slave port // access port
);
  logic [15:0] mem_q [0:(1<<CB_AW)-1];
  logic [15:0] rdata_q;

  // byte lanes written independently; read data from a register
  always_ff @(posedge ref_clk) begin
    if (port.req && port.we) begin
      if (port.be[0]) mem_q[port.addr][7:0] <= port.wdata[7:0];
      if (port.be[1]) mem_q[port.addr][15:8] <= port.wdata[15:8];
    end
    if (port.req) begin
      rdata_q <= mem_q[port.addr];
    end
  end
  assign port.rdata = rdata_q;
endmodule
`default_nettype wire

/* rtl/ebiu_pkg.sv */
// Purpose: shared constants for the external bus interface unit
// Assumes: 40 MHz ref_clk, four clock phases per bus cycle
// Notes: register offsets are byte addresses on the Avalon-MM slave
package ebiu_pkg;
  // software register map (word aligned byte offsets)
  localparam logic [7:0] OFS_UPPER_SEL = 8'h00;
  localparam logic [7:0] OFS_LOWER_SEL = 8'h04;
  localparam logic [7:0] OFS_BLOCK_BASE = 8'h08;
  localparam logic [7:0] OFS_BUS_CFG = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // field positions
  localparam int ADDR_DISABLE_POS = 7;
  localparam int BOOT8_POS = 0;
  localparam int UPPER_BUS8_POS = 1;
  localparam int LOWER_BUS8_POS = 2;
  localparam int MID_BUS8_POS = 3;
  localparam int IO_BUS8_POS = 4;
  // reset values
  localparam logic [15:0] UPPER_SEL_RST = 16'hF000;
  localparam logic [15:0] LOWER_SEL_RST = 16'h1000;
  localparam logic [15:0] BLOCK_BASE_RST = 16'hFC00;
  localparam logic [4:0] BUS_CFG_RST = 5'h00;
  // control block geometry: 1 Kbyte, 512 words of 16 bits
  localparam int CB_BYTES = 1024;
  localparam int CB_AW = 9;
  // upper region: addresses at or above the boundary in upper_select_reg;
  // lower region: addresses below the boundary in lower_select_reg
  localparam logic [19:0] MEM_TOP = 20'hFFFFF;
  // bus cycle length in phases t1..t4
  localparam int PHASES = 4;
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4
  } bus_state_t;
endpackage

/* rtl/ebiu_top.sv */
// Purpose: external bus interface unit with control block decode
// Assumes: one processor or DMA request at a time on a simple port
// Notes: phases t1..t4 each last one ref_clk cycle
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - control block: 16-bit registers in 1 Kbyte, base FC00h in I/O after reset
// - internal accesses go to control block, others to the external bus
// - multiplexed bus carries the address only in phase one, then data
// - demultiplexed address held over all four phases of the cycle
// - refresh drives the multiplexed bus in phase one only; address undefined
// - demultiplexed address valid half a clock before the muxed address; code leads by one ref_clk phase
// - suppressed upper or lower access leaves muxed bus floating in address phase
// - suppression enabled per region by addr_disable_bit in each select register
// - addr_drive_strap at reset overrides both addr_disable_bit settings
// - under suppression address goes only on demux_address, data on muxed bus
// - high_byte_write_n is byte_high_enable_n OR write_strobe_n
// - low_byte_write_n is address bit zero OR write_strobe_n
// - byte write enables follow demux_address timing
// - bus sizing, four chip selects, boot from 8- or 16-bit device
// - read_strobe_n low while reading a word or byte
module ebiu_top
  import ebiu_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic addr_drive_strap, // strap, caught at reset
  input wire logic boot_8bit_strap, // boot device width strap
  // Avalon-MM slave
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  // processor / DMA access port
  input wire logic acc_req, // start an access
  input wire logic acc_io, // I/O space when high
  input wire logic acc_write, // write when high
  input wire logic acc_refresh, // refresh cycle
  input wire logic [19:0] acc_addr, // byte address
  input wire logic [1:0] acc_be, // byte enables, bit1 = high byte
  input wire logic [15:0] acc_wdata, // write data
  output logic acc_ready, // access finished, pulse
  output logic [15:0] acc_rdata, // read data
  output logic acc_busy, // cycle in progress
  // external bus pins
  output logic [19:0] demux_address, // nonmultiplexed address
  input wire logic [15:0] muxed_addr_data_i, // pin input
  output logic [15:0] muxed_addr_data_o, // pin output
  output logic muxed_addr_data_oe, // pin drive enable
  output logic read_strobe_n, // output enable to memory
  output logic write_strobe_n, // write strobe
  output logic byte_high_enable_n, // high byte enable
  output logic high_byte_write_n, // high byte write enable
  output logic low_byte_write_n, // low byte write enable
  output logic upper_mem_select_n, // upper region chip select
  output logic lower_mem_select_n, // lower region chip select
  output logic mid_mem_select_n, // remaining memory chip select
  output logic io_select_n, // I/O chip select
  output logic bus_8bit // current cycle sized to 8 bits
);
  cb_if cb ();

  bus_state_t state_q;
  logic [15:0] upper_sel_q, lower_sel_q, block_base_q;
  logic [4:0] bus_cfg_q;
  logic strap_q;
  logic io_q, wr_q, rfsh_q, cb_q, sup_q;
  logic [19:0] addr_q;
  logic [1:0] be_q;
  logic [15:0] wdata_q, rdata_q;
  logic [19:0] demux_q, mux_o_q;
  logic mux_oe_q, rd_n_q, wr_n_q, bhe_n_q;
  logic ucs_n_q, lcs_n_q, mcs_n_q, ios_n_q, b8_q;
  logic ready_q;
  logic avs_ack_q;
  logic [31:0] avs_rd_q;

  // control block hit: I/O access inside 1 Kbyte above base
  function automatic logic cb_hit(input logic io, input logic [19:0] a,
    input logic [15:0] base);
    logic [19:0] off;
    off = a - {4'h0, base};
    cb_hit = io && (a >= {4'h0, base}) && (off < 20'(CB_BYTES));
  endfunction

  // region decode; boundaries from the top of the select registers
  function automatic logic in_upper(input logic [19:0] a,
    input logic [15:0] sel);
    in_upper = a >= {sel[15:8], 12'h000};
  endfunction
  function automatic logic in_lower(input logic [19:0] a,
    input logic [15:0] sel);
    in_lower = a < {sel[15:8], 12'h000};
  endfunction

  // strap caught while reset is held; later changes are ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_q <= addr_drive_strap;
    end
  end

  // software registers, written through the Avalon slave; the write lands
  // only at the edge where waitrequest is low, as the master expects
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      upper_sel_q <= UPPER_SEL_RST;
      lower_sel_q <= LOWER_SEL_RST;
      block_base_q <= BLOCK_BASE_RST;
      bus_cfg_q <= BUS_CFG_RST;
    end else if (avs_write && avs_ack_q) begin
      case (avs_address)
        OFS_UPPER_SEL: begin
          if (avs_byteenable[0]) upper_sel_q[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) upper_sel_q[15:8] <= avs_writedata[15:8];
        end
        OFS_LOWER_SEL: begin
          if (avs_byteenable[0]) lower_sel_q[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) lower_sel_q[15:8] <= avs_writedata[15:8];
        end
        OFS_BLOCK_BASE: begin
          if (avs_byteenable[1]) begin
            block_base_q[15:10] <= avs_writedata[15:10];
          end
        end
        OFS_BUS_CFG: begin
          if (avs_byteenable[0]) bus_cfg_q <= avs_writedata[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  // one wait state per access: ack on the second cycle of a request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_ack_q <= 1'b0;
      avs_rd_q <= 32'h0000_0000;
    end else begin
      avs_ack_q <= (avs_read || avs_write) && !avs_ack_q;
      case (avs_address)
        OFS_UPPER_SEL: avs_rd_q <= {16'h0000, upper_sel_q};
        OFS_LOWER_SEL: avs_rd_q <= {16'h0000, lower_sel_q};
        OFS_BLOCK_BASE: avs_rd_q <= {16'h0000, block_base_q};
        OFS_BUS_CFG: avs_rd_q <= {27'h0000000, bus_cfg_q};
        OFS_STATUS: avs_rd_q <= {28'h0000000, strap_q, boot_8bit_strap,
          acc_busy, sup_q};
        default: avs_rd_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !avs_ack_q;
  assign avs_readdata = avs_rd_q;

  // bus cycle sequencer: t1..t4, one clock each
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (acc_req) state_q <= ST_T1;
        ST_T1: state_q <= ST_T2;
        ST_T2: state_q <= ST_T3;
        ST_T3: state_q <= ST_T4;
        ST_T4: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // latch the request; demux_address leads the muxed address by a
  // phase, standing in for the half clock_out lead at this rate
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_q <= 20'h00000;
      io_q <= 1'b0;
      wr_q <= 1'b0;
      rfsh_q <= 1'b0;
      be_q <= 2'h0;
      wdata_q <= 16'h0000;
      cb_q <= 1'b0;
      sup_q <= 1'b0;
    end else if (state_q == ST_IDLE && acc_req) begin
      addr_q <= acc_addr;
      io_q <= acc_io;
      wr_q <= acc_write;
      rfsh_q <= acc_refresh;
      be_q <= acc_be;
      wdata_q <= acc_wdata;
      cb_q <= cb_hit(acc_io, acc_addr, block_base_q);
      // suppression per region unless the strap overrides it
      sup_q <= !strap_q && !acc_io && !acc_refresh &&
        ((in_upper(acc_addr, upper_sel_q) &&
          upper_sel_q[ADDR_DISABLE_POS]) ||
         (in_lower(acc_addr, lower_sel_q) &&
          lower_sel_q[ADDR_DISABLE_POS]));
    end
  end

  // pin drivers; control block cycles stay off the external strobes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      demux_q <= 20'h00000;
      mux_o_q <= 20'h00000;
      mux_oe_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      bhe_n_q <= 1'b1;
      ucs_n_q <= 1'b1;
      lcs_n_q <= 1'b1;
      mcs_n_q <= 1'b1;
      ios_n_q <= 1'b1;
      b8_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          mux_oe_q <= 1'b0;
          rd_n_q <= 1'b1;
          wr_n_q <= 1'b1;
          if (acc_req) begin
            demux_q <= acc_refresh ? 20'h00000 : acc_addr;
            bhe_n_q <= !acc_be[1];
          end
        end
        ST_T1: begin
          // address phase on the muxed bus
          mux_o_q <= {4'h0, addr_q[15:0]};
          mux_oe_q <= !sup_q && !cb_q;
          if (!cb_q && !rfsh_q) begin
            ucs_n_q <= !(!io_q && in_upper(addr_q, upper_sel_q));
            lcs_n_q <= !(!io_q && in_lower(addr_q, lower_sel_q));
            mcs_n_q <= !(!io_q && !in_upper(addr_q, upper_sel_q) &&
              !in_lower(addr_q, lower_sel_q));
            ios_n_q <= !io_q;
          end
          b8_q <= io_q ? bus_cfg_q[IO_BUS8_POS] :
            in_upper(addr_q, upper_sel_q) ?
              (bus_cfg_q[UPPER_BUS8_POS] | boot_8bit_strap) :
            in_lower(addr_q, lower_sel_q) ? bus_cfg_q[LOWER_BUS8_POS] :
              bus_cfg_q[MID_BUS8_POS];
        end
        ST_T2: begin
          // data phases; refresh releases the bus after t1
          mux_o_q <= {4'h0, wdata_q};
          mux_oe_q <= wr_q && !cb_q && !rfsh_q;
          rd_n_q <= !(!wr_q && !cb_q && !rfsh_q);
          wr_n_q <= !(wr_q && !cb_q && !rfsh_q);
        end
        ST_T3: begin
        end
        ST_T4: begin
          rd_n_q <= 1'b1;
          wr_n_q <= 1'b1;
          ucs_n_q <= 1'b1;
          lcs_n_q <= 1'b1;
          mcs_n_q <= 1'b1;
          ios_n_q <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // control block access in t2, external read data captured in t4
  assign cb.req = (state_q == ST_T2) && cb_q;
  assign cb.we = wr_q;
  assign cb.addr = addr_q[CB_AW:1] - block_base_q[CB_AW:1];
  assign cb.wdata = wdata_q;
  assign cb.be = be_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
      ready_q <= 1'b0;
    end else begin
      ready_q <= state_q == ST_T4;
      if (state_q == ST_T4 && !wr_q) begin
        rdata_q <= cb_q ? cb.rdata : muxed_addr_data_i;
      end
    end
  end

  cb_mem u_cb_mem (
    .ref_clk(ref_clk),
    .port(cb)
  );

  assign demux_address = demux_q;
  assign muxed_addr_data_o = mux_o_q[15:0];
  assign muxed_addr_data_oe = mux_oe_q;
  assign read_strobe_n = rd_n_q;
  assign write_strobe_n = wr_n_q;
  assign byte_high_enable_n = bhe_n_q;
  // low write enable built from demux address bit zero, high from byte_high_enable_n; neither from the muxed bus
  assign high_byte_write_n = bhe_n_q | wr_n_q;
  assign low_byte_write_n = demux_q[0] | wr_n_q;
  assign upper_mem_select_n = ucs_n_q;
  assign lower_mem_select_n = lcs_n_q;
  assign mid_mem_select_n = mcs_n_q;
  assign io_select_n = ios_n_q;
  assign bus_8bit = b8_q;
  assign acc_ready = ready_q;
  assign acc_rdata = rdata_q;
  assign acc_busy = state_q != ST_IDLE;
endmodule
`default_nettype wire

/* verif/ebiu_ext_mem.sv */
// Purpose: external static memory on the muxed and demux buses
// Assumes: word index from demux_address[8:1], no wait states
// Notes: a released bus toggles so stale data never reads back
`timescale 1ns/100ps
`default_nettype none
module ebiu_ext_mem (
  input wire logic ref_clk, // clock
  input wire logic [19:0] demux_address, // address pins
  input wire logic [15:0] ad_o, // device drive value
  input wire logic ad_oe, // device drives
  input wire logic read_strobe_n, // output enable
  input wire logic high_byte_write_n, // high write enable
  input wire logic low_byte_write_n, // low write enable
  output logic [15:0] ad_i // resolved pin level
);
  logic [15:0] mem [256];
  logic [15:0] last_q = 16'h0000;
  // pin level: device first, memory on output enable, else float
  always_comb begin
    if (ad_oe)
      ad_i = ad_o;
    else if (!read_strobe_n)
      ad_i = mem[demux_address[8:1]];
    else
      ad_i = ~last_q;
  end
  // byte lanes written only by their own enable
  always_ff @(posedge ref_clk) begin
    last_q <= ad_i;
    if (!high_byte_write_n)
      mem[demux_address[8:1]][15:8] <= ad_i[15:8];
    if (!low_byte_write_n)
      mem[demux_address[8:1]][7:0] <= ad_i[7:0];
  end
endmodule
`default_nettype wire

/* verif/ebiu_top_chk.sv */
// Purpose: port-level checks for the external bus unit
// Assumes: access taken when acc_req is high and acc_busy low
// Notes: suppression state is not visible here; bench judges it
`timescale 1ns/100ps
`default_nettype none
module ebiu_top_chk (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic acc_req, // request
  input wire logic acc_busy, // busy
  input wire logic acc_io, // I/O space
  input wire logic acc_write, // write
  input wire logic acc_refresh, // refresh
  input wire logic [19:0] acc_addr, // address
  input wire logic [15:0] acc_wdata, // write data
  input wire logic acc_ready, // done
  input wire logic [19:0] demux_address, // address pins
  input wire logic [15:0] muxed_addr_data_o, // muxed out
  input wire logic muxed_addr_data_oe, // muxed drive
  input wire logic read_strobe_n, // read strobe
  input wire logic write_strobe_n, // write strobe
  input wire logic byte_high_enable_n, // high byte
  input wire logic high_byte_write_n, // high write
  input wire logic low_byte_write_n // low write
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // start of a cycle; ext is a plain memory cycle
  logic take, ext;
  assign take = acc_req && !acc_busy;
  assign ext = take && !acc_io && !acc_refresh;
  hb_write_a: assert property (
    high_byte_write_n == (byte_high_enable_n | write_strobe_n))
    else $error("high byte write enable wrong");
  lb_write_a: assert property (
    low_byte_write_n == (demux_address[0] | write_strobe_n))
    else $error("low byte write enable wrong");
  addr_hold_a: assert property (ext |=>
    demux_address == $past(acc_addr) ##1 $stable(demux_address) [*3])
    else $error("demux address not held");
  ready_lat_a: assert property (take |-> ##5 acc_ready)
    else $error("ready not five edges after start");
  wr_data_a: assert property (ext && acc_write |-> ##3
    muxed_addr_data_oe && muxed_addr_data_o == $past(acc_wdata, 3))
    else $error("write data missing in data phase");
  rd_strobe_a: assert property (ext && !acc_write |-> ##3
    !read_strobe_n && write_strobe_n)
    else $error("read strobe missing");
  addr_lead_a: assert property (ext |-> ##2 muxed_addr_data_oe |->
    muxed_addr_data_o == demux_address[15:0] && $stable(demux_address))
    else $error("muxed address without earlier demux");
  refresh_a: assert property (take && acc_refresh |-> ##3
    !muxed_addr_data_oe [*2])
    else $error("refresh drives muxed bus late");
  c_wr: cover property (ext && acc_write);
  c_rd: cover property (ext && !acc_write);
  c_rf: cover property (take && acc_refresh);
endmodule
bind ebiu_top ebiu_top_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .acc_req(acc_req), .acc_busy(acc_busy), .acc_io(acc_io),
  .acc_write(acc_write), .acc_refresh(acc_refresh), .acc_addr(acc_addr),
  .acc_wdata(acc_wdata), .acc_ready(acc_ready),
  .demux_address(demux_address), .muxed_addr_data_o(muxed_addr_data_o),
  .muxed_addr_data_oe(muxed_addr_data_oe), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .byte_high_enable_n(byte_high_enable_n),
  .high_byte_write_n(high_byte_write_n),
  .low_byte_write_n(low_byte_write_n));
`default_nettype wire

/* verif/external_bus_interface_unit_tb_top.sv */
// Purpose: self-checking bench for ebiu_top
// Assumes: 40 MHz clock, access port idle between calls
// Notes: memory model resolves the muxed pins
`timescale 1ns/100ps
`default_nettype none
module external_bus_interface_unit_tb_top
  import ebiu_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, strap = 0;
  logic [7:0] avs_address = 0;
  logic avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic acc_req = 0, acc_io = 0, acc_write = 0, acc_refresh = 0;
  logic [19:0] acc_addr = 0, demux_address;
  logic [1:0] acc_be = 0;
  logic [15:0] acc_wdata = 0, acc_rdata, ad_o, ad_i;
  logic acc_ready, acc_busy, ad_oe, rd_n, wr_n, bhe_n, hbw_n, lbw_n;
  wire [3:0] sel_n;
  logic [3:0] sel2;
  logic oe2, rd3, boot8 = 0, b8;
  int err_total = 0, checks_done = 0;
  // clock
  initial forever #12.5 ref_clk = ~ref_clk;
  ebiu_top DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr_drive_strap(strap), .boot_8bit_strap(boot8),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .acc_req(acc_req), .acc_io(acc_io), .acc_write(acc_write),
    .acc_refresh(acc_refresh), .acc_addr(acc_addr), .acc_be(acc_be),
    .acc_wdata(acc_wdata), .acc_ready(acc_ready), .acc_rdata(acc_rdata),
    .acc_busy(acc_busy), .demux_address(demux_address),
    .muxed_addr_data_i(ad_i), .muxed_addr_data_o(ad_o),
    .muxed_addr_data_oe(ad_oe), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .byte_high_enable_n(bhe_n),
    .high_byte_write_n(hbw_n), .low_byte_write_n(lbw_n),
    .upper_mem_select_n(sel_n[3]), .lower_mem_select_n(sel_n[2]),
    .mid_mem_select_n(sel_n[1]), .io_select_n(sel_n[0]), .bus_8bit(b8));
  ebiu_ext_mem mem (.ref_clk(ref_clk), .demux_address(demux_address),
    .ad_o(ad_o), .ad_oe(ad_oe), .read_strobe_n(rd_n),
    .high_byte_write_n(hbw_n), .low_byte_write_n(lbw_n), .ad_i(ad_i));
  task automatic chk(input string nm, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // strap is only caught while reset is low, then dropped
  task automatic do_reset(input logic s);
    @(posedge ref_clk);
    rst_n <= 0;
    strap <= s;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1;
    strap <= 0;
  endtask
  // avalon cycle: request held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    if (n >= 20) chk("waitrequest", 0, 1);
  endtask
  // one access; samples pins mid-phase so edge updates have landed
  task automatic acc(input logic io, wr, rf, input logic [19:0] a,
    input logic [1:0] b, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    acc_req <= 1;
    acc_io <= io;
    acc_write <= wr;
    acc_refresh <= rf;
    acc_addr <= a;
    acc_be <= b;
    acc_wdata <= d;
    @(posedge ref_clk);
    acc_req <= 0;
    repeat (2) @(negedge ref_clk);
    oe2 = ad_oe;
    sel2 = sel_n;
    @(negedge ref_clk);
    rd3 = rd_n;
    while (acc_ready !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 10) chk("acc_ready", 1, 0);
  endtask
  // reset values and an unmapped hole
  task automatic t_regs;
    av(0, OFS_UPPER_SEL, 0);
    chk("upper_select_reg", 32'(UPPER_SEL_RST), q);
    av(0, OFS_LOWER_SEL, 0);
    chk("lower_select_reg", 32'(LOWER_SEL_RST), q);
    av(0, OFS_BLOCK_BASE, 0);
    chk("block base", 32'h0000FC00, q);
    av(0, 8'h40, 0);
    chk("unmapped read", 32'h00000000, q);
  endtask
  // word then odd high byte write, read back merged word
  task automatic t_mem;
    acc(0, 1, 0, 20'h00102, 2'h3, 16'hA55A);
    chk("lower select", 4'hB, sel2);
    chk("lower sizing", 0, b8);
    acc(0, 1, 0, 20'h00103, 2'h2, 16'h3C00);
    acc(0, 0, 0, 20'h00102, 2'h3, 16'h0000);
    chk("merged read", 16'h3C5A, acc_rdata);
    chk("addr phase drive", 1, oe2);
    chk("read strobe", 0, rd3);
  endtask
  // lower region suppressed unless strapped; upper keeps driving
  task automatic t_supp(input logic strapped);
    av(1, OFS_LOWER_SEL, 32'h00001080);
    boot8 <= strapped;
    acc(0, 0, 0, 20'h00102, 2'h3, 16'h0000);
    chk("lower addr drive", strapped, oe2);
    chk("data only read", 16'h3C5A, acc_rdata);
    acc(0, 0, 0, 20'hF0010, 2'h3, 16'h0000);
    chk("upper addr drive", 1, oe2);
    chk("upper select", 4'h7, sel2);
    chk("upper sizing", strapped, b8);
  endtask
  // control block by direct access only; base moved away after
  task automatic t_cb;
    acc(1, 1, 0, 20'h0FC10, 2'h3, 16'hBEEF);
    acc(1, 0, 0, 20'h0FC10, 2'h3, 16'h0000);
    chk("cb read", 16'hBEEF, acc_rdata);
    chk("cb pins quiet", 5'h1F, {rd3, sel2});
    av(1, OFS_BLOCK_BASE, 32'h00008000);
    acc(1, 1, 0, 20'h08022, 2'h3, 16'h0F0F);
    acc(1, 0, 0, 20'h08022, 2'h3, 16'h0000);
    chk("moved cb read", 16'h0F0F, acc_rdata);
    acc(1, 0, 0, 20'h0FC10, 2'h3, 16'h0000);
    chk("ext io cycle", 5'h0E, {rd3, sel2});
  endtask
  initial begin
    do_reset(0);
    t_regs;
    t_mem;
    t_supp(0);
    t_cb;
    acc(0, 0, 1, 20'h00000, 2'h3, 16'h0000);
    do_reset(1);
    t_supp(1);
    close_out;
  end
  // watchdog at 4000 cycles, well beyond the 110 or so cycles used
  initial begin
    #100000;
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire
